//--- verilog/dsmc_top.sv
// drive state and mode command interpreter
`timescale 1ns/1ns
module dsmc_top
  import dsmc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic frame_valid,
  input wire dsmc_pkg::dsmc_frame_type frame,
  input wire logic acyc_write,
  input wire logic [7:0] acyc_control_word,
  input wire logic [7:0] input_pins,
  input wire logic [31:0] actual_position,
  input wire logic [31:0] configurable_data,
  input wire logic standstill,
  input wire logic init_done,
  input wire logic class1_error,
  input wire logic severe_error,
  input wire logic error_response_done,
  input wire logic warning,
  output dsmc_pkg::dsmc_return_type return_data,
  output logic return_valid,
  output logic power_stage_on,
  output logic quick_stop,
  output logic halt,
  output logic mode_start,
  output dsmc_pkg::dsmc_job_type mode_job,
  output logic mode_running
);
  import dsmc_pkg::*;

  typedef enum logic [6:0] {
    S_DISABLED = 7'b000_0001,
    S_READY = 7'b000_0010,
    S_SWITCHED_ON = 7'b000_0100,
    S_OP_ENABLED = 7'b000_1000,
    S_QUICK_STOP = 7'b001_0000,
    S_FAULT_REACT = 7'b010_0000,
    S_FAULT = 7'b100_0000
  } dsmc_state_type;

  // two-stage synchronisers for pins and external status levels
  logic [7:0] pins_s1, pins_s2;
  logic [5:0] stat_s1, stat_s2;
  always_ff @(posedge mclk) begin
    if (srst) begin
      pins_s1 <= 8'h00;
      pins_s2 <= 8'h00;
      stat_s1 <= 6'b00_0000;
      stat_s2 <= 6'b00_0000;
    end else begin
      pins_s1 <= input_pins;
      pins_s2 <= pins_s1;
      stat_s1 <= {standstill, init_done, class1_error, severe_error,
                  error_response_done, warning};
      stat_s2 <= stat_s1;
    end
  end
  logic still, inited, err1, err_sev, err_done, warn;
  always_comb begin
    {still, inited, err1, err_sev, err_done, warn} = stat_s2;
  end

  // edge detection on the cyclic control word and mode toggle
  logic [7:0] cw_rise;
  logic mode_toggled;
  dsmc_edge u_edge (
    .mclk(mclk),
    .srst(srst),
    .sample(frame_valid),
    .cw(frame.state_change_control_word),
    .toggle_in(frame.mode_select_and_toggle[MODE_TOGGLE_POS]),
    .rise(cw_rise),
    .toggled(mode_toggled)
  );

  // cyclic edges and acyclic level writes merge into one command set
  logic [7:0] cmd;
  always_comb begin
    cmd = cw_rise;
    if (acyc_write) begin
      cmd = cmd | acyc_control_word;
    end
    cmd[CW_RESERVED] = 1'b0;
  end

  // encoding of the one-hot state into the reported number
  function automatic logic [3:0] state_code(input dsmc_state_type s);
    case (s)
      S_DISABLED: state_code = ST_SWITCH_ON_DISABLED;
      S_READY: state_code = ST_READY;
      S_SWITCHED_ON: state_code = ST_SWITCHED_ON;
      S_OP_ENABLED: state_code = ST_OP_ENABLED;
      S_QUICK_STOP: state_code = ST_QUICK_STOP;
      S_FAULT_REACT: state_code = ST_FAULT_REACTION;
      S_FAULT: state_code = ST_FAULT;
      default: state_code = ST_RESET_VALUE;
    endcase
  endfunction : state_code

  // known mode code check
  function automatic logic code_known(input logic [6:0] c);
    case (c)
      MC_JOG, MC_VELOCITY: code_known = 1'b1;
      MC_DIM_SET, MC_REF_MOVE: code_known = 1'b1;
      MC_POS_ABS, MC_POS_REL_TGT, MC_POS_REL_MOT: code_known = 1'b1;
      MC_GEAR_RT, MC_GEAR_COMP: code_known = 1'b1;
      MC_CURRENT, MC_SPEED: code_known = 1'b1;
      default: code_known = 1'b0;
    endcase
  endfunction : code_known

  function automatic logic is_torque_speed(input logic [6:0] c);
    is_torque_speed = (c == MC_CURRENT) || (c == MC_SPEED);
  endfunction : is_torque_speed

  // operating state machine
  dsmc_state_type state, next_state;
  logic class1_qs;
  always_comb begin
    next_state = state;
    case (state)
      S_DISABLED: begin
        if (inited) begin
          next_state = S_READY;
        end
      end
      S_READY: begin
        if (cmd[CW_ENABLE]) begin
          next_state = S_SWITCHED_ON;
        end
      end
      S_SWITCHED_ON: begin
        if (cmd[CW_DISABLE]) begin
          next_state = S_DISABLED;
        end else begin
          next_state = S_OP_ENABLED;
        end
      end
      S_OP_ENABLED: begin
        if (cmd[CW_DISABLE]) begin
          next_state = S_DISABLED;
        end else if (cmd[CW_QSTOP] || err1) begin
          next_state = S_QUICK_STOP;
        end
      end
      S_QUICK_STOP: begin
        if (cmd[CW_DISABLE]) begin
          next_state = S_DISABLED;
        end else if (cmd[CW_FAULT_CLEAR] && class1_qs) begin
          next_state = S_OP_ENABLED;
        end
      end
      S_FAULT_REACT: begin
        if (err_done) begin
          next_state = S_FAULT;
        end
      end
      S_FAULT: begin
        if (cmd[CW_FAULT_CLEAR] && !err_sev) begin
          next_state = S_DISABLED;
        end
      end
      default: next_state = S_DISABLED;
    endcase
    if (err_sev && state != S_FAULT_REACT && state != S_FAULT) begin
      next_state = S_FAULT_REACT;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= S_DISABLED;
    end else begin
      state <= next_state;
    end
  end

  // quick stop cause: remembered class 1 error
  always_ff @(posedge mclk) begin
    if (srst) begin
      class1_qs <= 1'b0;
    end else if (state == S_OP_ENABLED && next_state == S_QUICK_STOP) begin
      class1_qs <= err1;
    end
  end

  // halt condition; set wins if both edges arrive together
  logic halted_mode;
  always_ff @(posedge mclk) begin
    if (srst) begin
      halt <= 1'b0;
    end else if (cmd[CW_HALT_SET]) begin
      halt <= 1'b1;
    end else if (cmd[CW_HALT_CLEAR]) begin
      halt <= 1'b0;
    end
  end

  // mode acceptance
  logic [6:0] req_code;
  logic mode_allowed, accept, resume;
  dsmc_job_type cur_job, new_job;
  always_comb begin
    req_code = frame.mode_select_and_toggle[6:0];
    new_job.code = req_code;
    new_job.ref_16 = frame.reference_word_two;
    new_job.ref_32 = {frame.reference_word_three, frame.reference_word_four};
    mode_allowed = (state == S_OP_ENABLED) && code_known(req_code) && !halt;
    if (mode_running) begin
      mode_allowed = mode_allowed && is_torque_speed(req_code)
                     && is_torque_speed(cur_job.code);
    end
    accept = mode_toggled && mode_allowed;
    resume = cmd[CW_CONTINUE] && halted_mode && !halt
             && (state == S_OP_ENABLED);
  end

  dsmc_regs u_regs (
    .mclk(mclk),
    .srst(srst),
    .we(accept),
    .wdata(new_job),
    .rdata(cur_job)
  );

  // running, completion and halt bookkeeping
  logic mode_done, mode_refused, toggle_echo;
  // start pulse and the job handed to the motion core
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_start <= 1'b0;
      mode_job <= '0;
    end else begin
      mode_start <= accept | resume;
      if (accept) begin
        mode_job <= new_job;
      end else if (resume) begin
        mode_job <= cur_job;
      end
    end
  end

  // toggle echo and refusal flag
  always_ff @(posedge mclk) begin
    if (srst) begin
      toggle_echo <= 1'b0;
      mode_refused <= 1'b0;
    end else if (accept) begin
      toggle_echo <= frame.mode_select_and_toggle[MODE_TOGGLE_POS];
      mode_refused <= 1'b0;
    end else if (mode_toggled) begin
      mode_refused <= 1'b1;
    end
  end

  // running, completion and halted-mode tracking
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_running <= 1'b0;
      halted_mode <= 1'b0;
      mode_done <= 1'b0;
    end else begin
      if (accept || resume) begin
        mode_running <= 1'b1;
        mode_done <= 1'b0;
        halted_mode <= 1'b0;
      end else if (mode_running && state != S_OP_ENABLED) begin
        mode_running <= 1'b0; // discontinued by state change
        halted_mode <= 1'b0;
      end else if (mode_running && still && !mode_start) begin
        mode_running <= 1'b0;
        mode_done <= 1'b1;
        halted_mode <= halt;
      end
    end
  end

  // return strobe follows each frame by one cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      return_valid <= 1'b0;
    end else begin
      return_valid <= frame_valid;
    end
  end

  // power stage and quick stop outputs decoded from the state
  always_ff @(posedge mclk) begin
    if (srst) begin
      power_stage_on <= 1'b0;
      quick_stop <= 1'b0;
    end else begin
      power_stage_on <= (state == S_OP_ENABLED) || (state == S_QUICK_STOP);
      quick_stop <= (state == S_QUICK_STOP);
    end
  end

  // returned process data
  always_ff @(posedge mclk) begin
    if (srst) begin
      return_data <= '0;
    end else begin
      return_data.drive_state_report <= '0;
      return_data.drive_state_report[DSR_STATE_LSB +: 4] <= state_code(state);
      return_data.drive_state_report[DSR_WARN] <= warn;
      return_data.drive_state_report[DSR_ERROR] <= (state == S_FAULT)
                                                   || (state == S_FAULT_REACT);
      return_data.drive_state_report[DSR_HALT] <= halt;
      return_data.drive_state_report[DSR_MODE_ACTIVE] <= mode_running;
      return_data.drive_state_report[DSR_MODE_DONE] <= mode_done;
      return_data.drive_state_report[DSR_MODE_REFUSED] <= mode_refused;
      return_data.drive_state_report[DSR_POWER_ON] <= power_stage_on;
      return_data.active_mode_report <= {toggle_echo, cur_job.code};
      return_data.input_signals <= pins_s2;
      return_data.actual_position <= actual_position;
      if (frame_valid) begin
        return_data.configurable <= configurable_data;
      end
    end
  end
endmodule : dsmc_top

//--- verilog/dsmc_pkg.sv
// shared constants and types for the drive state and mode command block
package dsmc_pkg;
  // operating state codes
  localparam logic [3:0] ST_SWITCH_ON_DISABLED = 4'h3;
  localparam logic [3:0] ST_READY = 4'h4;
  localparam logic [3:0] ST_SWITCHED_ON = 4'h5;
  localparam logic [3:0] ST_OP_ENABLED = 4'h6;
  localparam logic [3:0] ST_QUICK_STOP = 4'h7;
  localparam logic [3:0] ST_FAULT_REACTION = 4'h8;
  localparam logic [3:0] ST_FAULT = 4'h9;
  localparam logic [3:0] ST_RESET_VALUE = 4'h3;
  // control word bit positions
  localparam int CW_DISABLE = 0;
  localparam int CW_ENABLE = 1;
  localparam int CW_QSTOP = 2;
  localparam int CW_FAULT_CLEAR = 3;
  localparam int CW_RESERVED = 4;
  localparam int CW_HALT_SET = 5;
  localparam int CW_HALT_CLEAR = 6;
  localparam int CW_CONTINUE = 7;
  localparam int MODE_TOGGLE_POS = 7;
  // mode action codes
  localparam logic [6:0] MC_NONE = 7'h00;
  localparam logic [6:0] MC_JOG = 7'h01;
  localparam logic [6:0] MC_DIM_SET = 7'h02;
  localparam logic [6:0] MC_REF_MOVE = 7'h12;
  localparam logic [6:0] MC_POS_ABS = 7'h03;
  localparam logic [6:0] MC_POS_REL_TGT = 7'h13;
  localparam logic [6:0] MC_POS_REL_MOT = 7'h23;
  localparam logic [6:0] MC_VELOCITY = 7'h04;
  localparam logic [6:0] MC_GEAR_RT = 7'h05;
  localparam logic [6:0] MC_GEAR_COMP = 7'h15;
  localparam logic [6:0] MC_CURRENT = 7'h16;
  localparam logic [6:0] MC_SPEED = 7'h17;
  // drive state report layout, bytes 9 and 10
  localparam int DSR_STATE_LSB = 0;
  localparam int DSR_WARN = 4;
  localparam int DSR_ERROR = 5;
  localparam int DSR_HALT = 6;
  localparam int DSR_MODE_ACTIVE = 7;
  localparam int DSR_MODE_DONE = 8;
  localparam int DSR_MODE_REFUSED = 9;
  localparam int DSR_POWER_ON = 10;
  // outgoing process data bytes
  typedef struct packed {
    logic [15:0] drive_state_report;
    logic [7:0] active_mode_report;
    logic [7:0] input_signals;
    logic [31:0] actual_position;
    logic [31:0] configurable;
  } dsmc_return_type;
  // incoming cyclic frame
  typedef struct packed {
    logic [7:0] state_change_control_word;
    logic [7:0] mode_select_and_toggle;
    logic [15:0] reference_word_two;
    logic [15:0] reference_word_three;
    logic [15:0] reference_word_four;
  } dsmc_frame_type;
  // accepted mode job towards the motion core
  typedef struct packed {
    logic [6:0] code;
    logic [15:0] ref_16;
    logic [31:0] ref_32;
  } dsmc_job_type;
endpackage : dsmc_pkg

//--- verilog/dsmc_edge.sv
// rising edge and toggle detection across process-data cycles
`timescale 1ns/1ns
module dsmc_edge (
  input wire logic mclk,
  input wire logic srst,
  input wire logic sample,
  input wire logic [7:0] cw,
  input wire logic toggle_in,
  output logic [7:0] rise,
  output logic toggled
);
  logic [7:0] cw_prev;
  logic toggle_prev;
  // previous samples kept per cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      cw_prev <= 8'h00;
      toggle_prev <= 1'b0;
    end else if (sample) begin
      cw_prev <= cw;
      toggle_prev <= toggle_in;
    end
  end
  // edge events valid only with the cycle strobe
  always_comb begin
    rise = sample ? (cw & ~cw_prev) : 8'h00;
    toggled = sample & (toggle_in ^ toggle_prev);
  end
endmodule : dsmc_edge

//--- verilog/dsmc_regs.sv
// small register store for the accepted mode job
`timescale 1ns/1ns
module dsmc_regs
  import dsmc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic we,
  input wire dsmc_pkg::dsmc_job_type wdata,
  output dsmc_pkg::dsmc_job_type rdata
);
  // registered read data
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata <= '0;
    end else if (we) begin
      rdata <= wdata;
    end
  end
endmodule : dsmc_regs

//--- tb/dsmc_monitor.sv
// assertion checker for the drive state and mode command block
`timescale 1ns/1ns
module dsmc_monitor
  import dsmc_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic frame_valid,
  input wire dsmc_pkg::dsmc_frame_type frame,
  input wire logic acyc_write,
  input wire logic [7:0] acyc_control_word,
  input wire logic [31:0] actual_position,
  input wire dsmc_pkg::dsmc_return_type return_data,
  input wire logic return_valid,
  input wire logic power_stage_on,
  input wire logic quick_stop,
  input wire logic halt,
  input wire logic mode_start,
  input wire dsmc_pkg::dsmc_job_type mode_job
);
  logic [7:0] cw_q;
  logic tg_q;
  logic [7:0] rise;
  logic halt_req;
  logic cont_req;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // last control word and toggle of the previous frame
  always_ff @(posedge mclk) begin
    if (srst) begin
      cw_q <= 8'h00;
      tg_q <= 1'b0;
    end else if (frame_valid) begin
      cw_q <= frame.state_change_control_word;
      tg_q <= frame.mode_select_and_toggle[7];
    end
  end
  // rising control bits and halt requests
  assign rise = {8{frame_valid}} & frame.state_change_control_word & ~cw_q;
  assign halt_req = rise[5] | (acyc_write & acyc_control_word[5]);
  assign cont_req = rise[7] | (acyc_write & acyc_control_word[7]);
  a_valid_after_frame: assert property (frame_valid |=> return_valid)
    else $error("return_valid missing after frame");
  a_valid_has_cause: assert property (return_valid |-> $past(frame_valid))
    else $error("return_valid without frame");
  a_start_on_toggle: assert property (mode_start |-> $past(cont_req) ||
    ($past(frame_valid) && ($past(frame.mode_select_and_toggle[7]) != $past(tg_q))))
    else $error("start without toggle");
  a_job_from_frame: assert property (mode_start |-> $past(cont_req) ||
    (mode_job == $past(frame[54:0]))) else $error("mode job differs from frame");
  a_mirror_toggle: assert property (mode_start |=>
    return_data.active_mode_report == {$past(tg_q), $past(mode_job.code)})
    else $error("active mode report wrong");
  a_halt_on_rise: assert property (rise[5] |=> halt)
    else $error("halt not set");
  a_halt_cause: assert property ($rose(halt) |-> $past(halt_req))
    else $error("halt set without edge");
  a_stop_powered: assert property (quick_stop |-> power_stage_on)
    else $error("quick stop without power");
  a_data_passed: assert property (!$past(srst) |->
    return_data.actual_position == $past(actual_position)) else $error("position stale");
  c_mode_start: cover property (mode_start);
  c_halt: cover property ($rose(halt));
  c_quick_stop: cover property ($rose(quick_stop));
  c_resume: cover property (mode_start && $past(cont_req));
endmodule : dsmc_monitor

bind dsmc_top dsmc_monitor u_monitor (.mclk, .srst, .frame_valid, .frame, .acyc_write,
  .acyc_control_word, .actual_position, .return_data, .return_valid, .power_stage_on,
  .quick_stop, .halt, .mode_start, .mode_job);

//--- tb/dsmc_master.sv
// fieldbus master model sending process-data frames
`timescale 1ns/1ns
module dsmc_master
  import dsmc_pkg::*;
(
  input wire logic mclk,
  output logic frame_valid,
  output dsmc_pkg::dsmc_frame_type frame
);
  logic toggle;
  // idle lines start at a pattern, not a frame
  initial begin
    frame_valid = 1'b0;
    toggle = 1'b0;
    frame = '1;
  end
  // one frame of control bits, mode byte and references
  task automatic send(input logic [7:0] cw, input logic flip, input logic [6:0] code,
                      input logic [47:0] refs);
    @(negedge mclk);
    if (flip) begin
      toggle = ~toggle;
    end
    frame_valid = 1'b1;
    frame = {cw & 8'hef, toggle, code, refs};
    @(negedge mclk);
    frame_valid = 1'b0;
    frame = ~frame; // released lines carry the inverse of the last value
  endtask : send
endmodule : dsmc_master

//--- tb/dsmc_top_test.sv
// self-checking bench for the drive state and mode command block
`timescale 1ns/1ns
module dsmc_top_test;
  import dsmc_pkg::*;
  // control word, error/acyclic flags, state, halt
  localparam logic [19:0] STEPS [18] = '{20'h0_2060, 20'h0_2060, 20'h0_3040, 20'h0_2040,
    20'h0_0040, 20'h0_2060, 20'h2_2061, 20'h4_2060, 20'h6_2061, 20'h0_2061, 20'h4_2060,
    20'h0_2870, 20'h0_a060, 20'h0_6070, 20'h0_6480, 20'h0_6290, 20'h0_e040, 20'h0_2160};
  localparam logic [6:0] CODES [11] = '{MC_JOG, MC_DIM_SET, MC_REF_MOVE, MC_POS_ABS,
    MC_POS_REL_TGT, MC_POS_REL_MOT, MC_VELOCITY, MC_GEAR_RT, MC_GEAR_COMP, MC_CURRENT,
    MC_SPEED};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic acyc_write = 1'b0;
  logic [7:0] acyc_control_word = 8'h00;
  logic [7:0] input_pins = 8'h00;
  logic [31:0] actual_position = 32'h0000_0000;
  logic [31:0] configurable_data = 32'h0000_0000;
  logic standstill = 1'b0;
  logic init_done = 1'b0;
  logic class1_error = 1'b0;
  logic severe_error = 1'b0;
  logic error_response_done = 1'b0;
  logic warning = 1'b0;
  logic frame_valid;
  dsmc_frame_type frame;
  dsmc_return_type return_data;
  dsmc_job_type mode_job;
  logic return_valid, power_stage_on, quick_stop, halt, mode_start, mode_running;
  logic [47:0] refs = 48'h0000_0000_0000;
  int bad_count = 0;
  int comparisons = 0;
  dsmc_master u_master (.mclk(mclk), .frame_valid(frame_valid), .frame(frame));
  dsmc_top u_dut (.mclk(mclk), .srst(srst), .frame_valid(frame_valid), .frame(frame),
    .acyc_write(acyc_write), .acyc_control_word(acyc_control_word),
    .input_pins(input_pins), .actual_position(actual_position),
    .configurable_data(configurable_data), .standstill(standstill),
    .init_done(init_done), .class1_error(class1_error), .severe_error(severe_error),
    .error_response_done(error_response_done), .warning(warning),
    .return_data(return_data), .return_valid(return_valid),
    .power_stage_on(power_stage_on), .quick_stop(quick_stop), .halt(halt),
    .mode_start(mode_start), .mode_job(mode_job), .mode_running(mode_running));
  // clock, 100 ns period
  always #50 mclk = ~mclk;
  // compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // power stage expected on in operation enabled and quick stop
  function automatic logic powered(input logic [3:0] st);
    powered = (st == ST_OP_ENABLED) || (st == ST_QUICK_STOP);
  endfunction : powered
  task automatic wait_cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : wait_cycles
  // one mode frame; counts the start pulse within a bounded window
  task automatic run_mode(input logic [6:0] code, input logic flip, input logic ok);
    logic got;
    got = 1'b0;
    refs = {$urandom(), 16'($urandom())};
    u_master.send(8'h02, flip, code, refs);
    for (int k = 0; k < 8; k++) begin
      if (mode_start === 1'b1) begin
        got = 1'b1;
        check(mode_job, {code, refs});
      end
      @(negedge mclk);
    end
    check(got, ok);
    if (ok) check(return_data.active_mode_report, {u_master.toggle, code});
    if (flip && !ok) check(return_data.drive_state_report[DSR_MODE_REFUSED], 1'b1);
  endtask : run_mode
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : test_done
  // bound on the whole run
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    test_done();
  end
  // main sequence
  initial begin
    void'($urandom(32'hcd96));
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    wait_cycles(3);
    check(return_data.drive_state_report[3:0], ST_RESET_VALUE);
    check(power_stage_on, 1'b0);
    actual_position = $urandom();
    configurable_data = $urandom();
    input_pins = 8'($urandom());
    warning = 1'b1;
    init_done = 1'b1;
    wait_cycles(6);
    check(return_data.actual_position, actual_position);
    check(return_data.input_signals, input_pins);
    check(return_data.drive_state_report[DSR_WARN], 1'b1);
    check(return_data.drive_state_report[3:0], ST_READY);
    $display("test report done");
    run_mode(MC_POS_ABS, 1'b1, 1'b0);
    check(return_data.configurable, configurable_data);
    for (int i = 0; i < 18; i++) begin
      {class1_error, severe_error, error_response_done} = STEPS[i][11:9];
      if (STEPS[i][8]) begin
        acyc_control_word = STEPS[i][19:12];
        acyc_write = 1'b1;
        @(negedge mclk);
        acyc_write = 1'b0;
      end else begin
        u_master.send(STEPS[i][19:12], 1'b0, MC_NONE, refs);
      end
      wait_cycles(8);
      check(return_data.drive_state_report[3:0],
        STEPS[i][7:4]);
      check(halt, STEPS[i][0]);
      check(return_data.drive_state_report[DSR_HALT], STEPS[i][0]);
      check(power_stage_on, powered(STEPS[i][7:4]));
      check(quick_stop, STEPS[i][7:4] == ST_QUICK_STOP);
    end
    $display("test states done");
    foreach (CODES[i]) begin
      standstill = 1'b0;
      wait_cycles(3);
      run_mode(CODES[i], 1'b1, 1'b1);
      if (CODES[i] != MC_CURRENT) begin
        standstill = 1'b1;
        wait_cycles(6);
        check(mode_running, 1'b0);
      end
    end
    run_mode(MC_POS_ABS, 1'b0, 1'b0);
    standstill = 1'b0;
    wait_cycles(3);
    run_mode(MC_VELOCITY, 1'b1, 1'b1);
    run_mode(MC_JOG, 1'b1, 1'b0);
    // halt at standstill, release, then continue resumes the halted job
    standstill = 1'b1;
    wait_cycles(6);
    standstill = 1'b0;
    wait_cycles(3);
    run_mode(MC_POS_ABS, 1'b1, 1'b1);
    u_master.send(8'h22, 1'b0, MC_NONE, refs);
    standstill = 1'b1;
    wait_cycles(6);
    check(halt, 1'b1);
    check(return_data.drive_state_report[DSR_MODE_DONE], 1'b1);
    standstill = 1'b0;
    u_master.send(8'h42, 1'b0, MC_NONE, refs);
    u_master.send(8'hc2, 1'b0, MC_NONE, refs);
    check(mode_start, 1'b1);
    check(mode_job, {MC_POS_ABS, refs});
    $display("test modes done");
    test_done();
  end
endmodule : dsmc_top_test
